// ===== logic/fcs_pkg.sv
// Shared constants, field layouts and types of the flash security register front end
package fcs_pkg;

  // ==========================================================================
  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CLKDIV = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SEC = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_TEST = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_CFG = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PROT = 4'h4;

  // ==========================================================================
  // Field codes and reset values
  localparam logic [1:0] KEY_ENABLED = 2'h2;
  localparam logic [1:0] LOCK_UNSECURED = 2'h2;
  localparam logic [DATA_W-1:0] TEST_READ_VALUE = 8'h00;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;

  // ==========================================================================
  // Configuration field in the array
  localparam int ARRAY_ADDR_W = 16;
  localparam int ARRAY_DATA_W = 16;
  localparam logic [ARRAY_ADDR_W-1:0] NV_KEY_BASE = 16'hff00;
  localparam logic [ARRAY_ADDR_W-1:0] NV_PROT_ADDR = 16'hff0d;
  localparam logic [ARRAY_ADDR_W-1:0] NV_SEC_ADDR = 16'hff0f;
  localparam int KEY_WORDS = 4;
  localparam int KEY_IDX_W = 2;
  localparam logic [3:0] LD_PROT_IDX = 4'h8;
  localparam logic [3:0] LD_SEC_IDX = 4'h9;
  localparam logic [KEY_IDX_W-1:0] KEY_LAST_IDX = 2'h3;

  // ==========================================================================
  // Flash timing clock
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int FLASH_CLK_MIN_KHZ = 150;
  localparam int FLASH_CLK_MAX_KHZ = 200;
  localparam int PRESCALE_RATIO = 8;
  localparam int MAX_DIV_RATIO = 512;
  localparam int GAP_W = 10;
  localparam logic [2:0] PRESCALE_LAST = 3'(PRESCALE_RATIO - 1);

  // ==========================================================================
  // Types
  typedef struct packed {
    logic loaded;
    logic prescale_by_eight;
    logic [5:0] divider_ratio_field;
  } fcs_clkdiv_s;

  typedef struct packed {
    logic [1:0] backdoor_enable_field;
    logic [3:0] user_persistent_flags;
    logic [1:0] lock_state_field;
  } fcs_sec_s;

  typedef struct packed {
    logic buffer_empty_irq_enable;
    logic command_done_irq_enable;
    logic key_write_mode;
  } fcs_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fcs_reg_req_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ARRAY_ADDR_W-1:0] addr;
    logic [ARRAY_DATA_W-1:0] wdata;
  } fcs_array_req_s;

  typedef enum logic [1:0] {
    LD_ISSUE = 2'b00,
    LD_CAPTURE = 2'b01,
    LD_DONE = 2'b10
  } fcs_load_e;

endpackage

// ===== logic/fcs_key_store.sv
// Small memory that holds the backdoor key words loaded at reset
`timescale 1ns/100ps
module fcs_key_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int IDX_W = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic we,
  input wire logic [IDX_W-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic re,
  input wire logic [IDX_W-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read data from a register so the compare sees a stable word
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata <= '0;
    end
    else if (re)
    begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ===== logic/fcs_regs.sv
// Flash controller front registers: divider, security, test, configuration, protection
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps

module fcs_regs
  import fcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire fcs_pkg::fcs_reg_req_s reg_req,
  output logic [fcs_pkg::DATA_W-1:0] reg_rdata,
  output logic nv_rd,
  output logic [fcs_pkg::ARRAY_ADDR_W-1:0] nv_addr,
  input wire logic [fcs_pkg::DATA_W-1:0] nv_rdata,
  output logic load_done,
  input wire fcs_pkg::fcs_array_req_s array_req,
  output logic cmd_seq_start,
  output logic array_read_invalid,
  input wire logic buffer_empty_flag,
  input wire logic command_done_flag,
  output logic irq_buffer_empty_req,
  output logic irq_command_done_req,
  output logic flash_clk_tick,
  output logic device_secured,
  output logic backdoor_enabled,
  output logic [fcs_pkg::DATA_W-1:0] flash_protection
);
  import fcs_pkg::*;

  // ==========================================================================
  // Reset-sequence loader
  fcs_load_e ld_state, next_ld_state;
  logic [3:0] ld_idx, next_ld_idx;
  logic [DATA_W-1:0] key_hi, next_key_hi;
  logic key_we;

  assign nv_rd = (ld_state == LD_ISSUE);
  assign load_done = (ld_state == LD_DONE);
  assign key_we = (ld_state == LD_CAPTURE) && !ld_idx[3] && ld_idx[0];

  always_comb
  begin
    if (ld_idx == LD_PROT_IDX)
      nv_addr = NV_PROT_ADDR;
    else if (ld_idx == LD_SEC_IDX)
      nv_addr = NV_SEC_ADDR;
    else
      nv_addr = NV_KEY_BASE + {12'h000, ld_idx};
  end

  always_comb
  begin
    next_ld_state = ld_state;
    next_ld_idx = ld_idx;
    next_key_hi = key_hi;
    unique case (ld_state)
      LD_ISSUE: next_ld_state = LD_CAPTURE;
      LD_CAPTURE:
      begin
        // Even key bytes are the high half of a big-endian word
        if (!ld_idx[3] && !ld_idx[0])
          next_key_hi = nv_rdata;
        if (ld_idx == LD_SEC_IDX)
          next_ld_state = LD_DONE;
        else
        begin
          next_ld_state = LD_ISSUE;
          next_ld_idx = ld_idx + 4'h1;
        end
      end
      LD_DONE: next_ld_state = LD_DONE;
      default: next_ld_state = LD_ISSUE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ld_state <= LD_ISSUE;
      ld_idx <= 4'h0;
      key_hi <= 8'h00;
    end
    else
    begin
      ld_state <= next_ld_state;
      ld_idx <= next_ld_idx;
      key_hi <= next_key_hi;
    end
  end

  // ==========================================================================
  // Registers
  fcs_clkdiv_s clkdiv, next_clkdiv;
  fcs_sec_s sec, next_sec;
  fcs_cfg_s cfg, next_cfg;
  logic [DATA_W-1:0] prot, next_prot, next_rdata;
  logic unsecure_evt, wr_ok;

  // Writes before the loads finish are dropped, never stalled
  assign wr_ok = reg_req.wr && load_done;
  assign backdoor_enabled = (sec.backdoor_enable_field == KEY_ENABLED);
  assign device_secured = (sec.lock_state_field != LOCK_UNSECURED);
  assign flash_protection = prot;

  always_comb
  begin
    next_clkdiv = clkdiv;
    next_sec = sec;
    next_cfg = cfg;
    next_prot = prot;
    if (wr_ok && reg_req.addr == OFF_CLKDIV && !clkdiv.loaded)
    begin
      next_clkdiv.prescale_by_eight = reg_req.wdata[6];
      next_clkdiv.divider_ratio_field = reg_req.wdata[5:0];
      next_clkdiv.loaded = 1'b1;
    end
    if (wr_ok && reg_req.addr == OFF_CFG)
    begin
      next_cfg.buffer_empty_irq_enable = reg_req.wdata[7];
      next_cfg.command_done_irq_enable = reg_req.wdata[6];
      if (backdoor_enabled)
        next_cfg.key_write_mode = reg_req.wdata[5];
    end
    if (ld_state == LD_CAPTURE && ld_idx == LD_PROT_IDX)
      next_prot = nv_rdata;
    if (ld_state == LD_CAPTURE && ld_idx == LD_SEC_IDX)
      next_sec = fcs_sec_s'(nv_rdata);
    if (unsecure_evt)
      next_sec.lock_state_field = LOCK_UNSECURED;
  end

  // Read data stand only in the cycle after the strobe
  always_comb
  begin
    next_rdata = RESET_BYTE;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        OFF_CLKDIV: next_rdata = clkdiv;
        OFF_SEC: next_rdata = sec;
        OFF_TEST: next_rdata = TEST_READ_VALUE;
        OFF_CFG: next_rdata = {cfg, 5'h00};
        OFF_PROT: next_rdata = prot;
        default: next_rdata = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clkdiv <= '0;
      sec <= '0;
      cfg <= '0;
      prot <= RESET_BYTE;
      reg_rdata <= RESET_BYTE;
    end
    else
    begin
      clkdiv <= next_clkdiv;
      sec <= next_sec;
      cfg <= next_cfg;
      prot <= next_prot;
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Flash timing divider
  logic [2:0] pre_cnt, next_pre_cnt;
  logic [5:0] div_cnt, next_div_cnt;
  logic next_tick, pre_tick;

  // Ratio is (field+1) times 1 or 8, so at most 64*8
  assign pre_tick = !clkdiv.prescale_by_eight || (pre_cnt == PRESCALE_LAST);

  always_comb
  begin
    next_pre_cnt = pre_cnt;
    next_div_cnt = div_cnt;
    next_tick = 1'b0;
    if (clkdiv.loaded)
    begin
      next_pre_cnt = pre_tick ? 3'h0 : pre_cnt + 3'h1;
      if (pre_tick)
      begin
        if (div_cnt == clkdiv.divider_ratio_field)
        begin
          next_div_cnt = 6'h00;
          next_tick = 1'b1;
        end
        else
          next_div_cnt = div_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
      flash_clk_tick <= 1'b0;
    end
    else
    begin
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      flash_clk_tick <= next_tick;
    end
  end

  // ==========================================================================
  // Array access steering and backdoor key compare
  logic key_hit, cmp_good, next_unsecure, next_cmd_start;
  logic cmp_pending, next_cmp_pending, cmp_order_ok, next_cmp_order_ok;
  logic key_mismatch, next_key_mismatch;
  logic [ARRAY_DATA_W-1:0] key_rdata, cmp_word, next_cmp_word;
  logic [KEY_IDX_W-1:0] key_count, next_key_count;

  // Key words must be written in order at 0xFF00..0xFF07
  assign key_hit = array_req.wr && load_done && cfg.key_write_mode &&
                   (array_req.addr[15:3] == NV_KEY_BASE[15:3]);
  assign cmp_good = (key_rdata == cmp_word) && cmp_order_ok;
  assign array_read_invalid = array_req.rd && cfg.key_write_mode;

  fcs_key_store #(
    .WIDTH(ARRAY_DATA_W),
    .DEPTH(KEY_WORDS),
    .IDX_W(KEY_IDX_W)
  ) u_key_store (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .we(key_we),
    .waddr(ld_idx[2:1]),
    .wdata({key_hi, nv_rdata}),
    .re(key_hit),
    .raddr(array_req.addr[2:1]),
    .rdata(key_rdata)
  );

  always_comb
  begin
    next_cmp_pending = key_hit;
    next_cmp_word = cmp_word;
    next_cmp_order_ok = cmp_order_ok;
    next_key_count = key_count;
    next_key_mismatch = key_mismatch;
    next_unsecure = 1'b0;
    next_cmd_start = array_req.wr && load_done && !cfg.key_write_mode;
    if (key_hit)
    begin
      next_cmp_word = array_req.wdata;
      next_cmp_order_ok = (array_req.addr[2:1] == key_count);
    end
    if (cmp_pending)
    begin
      if (key_count == KEY_LAST_IDX)
      begin
        next_unsecure = cmp_good && !key_mismatch;
        next_key_mismatch = 1'b0;
        next_key_count = '0;
      end
      else
      begin
        next_key_mismatch = key_mismatch || !cmp_good;
        next_key_count = key_count + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmp_pending <= 1'b0;
      cmp_word <= '0;
      cmp_order_ok <= 1'b0;
      key_count <= '0;
      key_mismatch <= 1'b0;
      unsecure_evt <= 1'b0;
      cmd_seq_start <= 1'b0;
    end
    else
    begin
      cmp_pending <= next_cmp_pending;
      cmp_word <= next_cmp_word;
      cmp_order_ok <= next_cmp_order_ok;
      key_count <= next_key_count;
      key_mismatch <= next_key_mismatch;
      unsecure_evt <= next_unsecure;
      cmd_seq_start <= next_cmd_start;
    end
  end

  // ==========================================================================
  // Interrupt requests
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_buffer_empty_req <= 1'b0;
      irq_command_done_req <= 1'b0;
    end
    else
    begin
      irq_buffer_empty_req <= cfg.buffer_empty_irq_enable && buffer_empty_flag;
      irq_command_done_req <= cfg.command_done_irq_enable && command_done_flag;
    end
  end

  // ==========================================================================
  // Assertions
  logic [GAP_W-1:0] gap_cnt, expect_gap;
  logic seen_tick;

  assign expect_gap = GAP_W'((({4'h0, clkdiv.divider_ratio_field} + 10'h001) <<
                      (clkdiv.prescale_by_eight ? 3 : 0)) - 10'h001);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_cnt <= '0;
      seen_tick <= 1'b0;
    end
    else
    begin
      gap_cnt <= flash_clk_tick ? '0 : gap_cnt + 10'h001;
      seen_tick <= seen_tick || flash_clk_tick;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  property p_div_once;
    clkdiv.loaded |=> $stable(clkdiv);
  endproperty
  a_div_once: assert property (p_div_once) else $error("divider changed after first write");

  property p_loaded_flag;
    reg_req.wr && load_done && reg_req.addr == OFF_CLKDIV |=> clkdiv.loaded;
  endproperty
  a_loaded_flag: assert property (p_loaded_flag) else $error("divider loaded flag not set");

  property p_tick_gap;
    flash_clk_tick && seen_tick && $past(flash_clk_tick, 2) == 1'b0 |-> gap_cnt == expect_gap;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("flash tick spacing wrong");

  property p_zero_reads;
    reg_req.rd && (reg_req.addr == OFF_TEST || reg_req.addr > OFF_PROT) |=> reg_rdata == 8'h00;
  endproperty
  a_zero_reads: assert property (p_zero_reads) else $error("unused offset read nonzero");

  property p_sec_ro;
    load_done && !unsecure_evt |=> $stable(sec);
  endproperty
  a_sec_ro: assert property (p_sec_ro) else $error("security byte changed");

  property p_unsecure;
    unsecure_evt |=> !device_secured && sec.lock_state_field == LOCK_UNSECURED;
  endproperty
  a_unsecure: assert property (p_unsecure) else $error("key success did not unsecure");

  property p_key_gate;
    !backdoor_enabled |=> $stable(cfg.key_write_mode);
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("key mode written while disabled");

  property p_irq_gate;
    !cfg.buffer_empty_irq_enable && !cfg.command_done_irq_enable ##1
      $stable(cfg) |-> !irq_buffer_empty_req && !irq_command_done_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked interrupt requested");

  property p_cmd_start;
    array_req.wr && load_done && !cfg.key_write_mode |=> cmd_seq_start && !cmp_pending;
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("array write did not start command");

  property p_hold;
    !load_done |-> clkdiv == '0 && cfg == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("registers moved before load finished");

  c_tick: cover property (flash_clk_tick ##[1:600] flash_clk_tick);
  c_unsecure: cover property (unsecure_evt);
  c_cmd: cover property (cmd_seq_start);
  c_key_read: cover property (array_read_invalid);
endmodule

// ===== verification/fcs_regs_test.sv
// Self-checking bench for the flash controller front registers
`timescale 1ns/100ps
module fcs_regs_test;
  import fcs_pkg::*;
  // ==========================================================================
  // Bench state
  localparam logic [7:0] PROT_BYTE = 8'h5c;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  fcs_reg_req_s reg_req = '0;
  fcs_array_req_s array_req = '0;
  logic [DATA_W-1:0] nv_rdata = 8'h00;
  logic buffer_empty_flag = 1'b0;
  logic command_done_flag = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] flash_protection;
  logic [ARRAY_ADDR_W-1:0] nv_addr;
  logic nv_rd, load_done, cmd_seq_start, array_read_invalid;
  logic irq_buffer_empty_req, irq_command_done_req, flash_clk_tick;
  logic device_secured, backdoor_enabled;
  logic [7:0] sec_byte = 8'ha9;
  int error_cnt = 0, tests_run = 0, cyc = 0;

  always #5 core_clk = ~core_clk;

  fcs_regs dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .nv_rd(nv_rd), .nv_addr(nv_addr), .nv_rdata(nv_rdata), .load_done(load_done),
    .array_req(array_req), .cmd_seq_start(cmd_seq_start),
    .array_read_invalid(array_read_invalid), .buffer_empty_flag(buffer_empty_flag),
    .command_done_flag(command_done_flag), .irq_buffer_empty_req(irq_buffer_empty_req),
    .irq_command_done_req(irq_command_done_req), .flash_clk_tick(flash_clk_tick),
    .device_secured(device_secured), .backdoor_enabled(backdoor_enabled),
    .flash_protection(flash_protection)
  );

  // ==========================================================================
  // Configuration field contents; key bytes are a fixed pattern
  function automatic logic [7:0] nv_byte(input logic [15:0] a);
    if (a == NV_SEC_ADDR)
      return sec_byte;
    if (a == NV_PROT_ADDR)
      return PROT_BYTE;
    return 8'hc3 ^ a[7:0];
  endfunction

  // Answers one cycle after each read; otherwise the line toggles, never holds old data
  always @(posedge core_clk)
    if (nv_rd)
      nv_rdata <= nv_byte(nv_addr);
    else
      nv_rdata <= ~nv_rdata;

  // ==========================================================================
  // Compare, verdict and bus tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d of %0d comparisons", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      error_cnt++;
      $display("[FAIL] %0t run did not finish in time", $time);
      give_verdict();
    end
  end

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
    chk_byte(reg_rdata, exp, what);
  endtask

  task automatic arr_wr(input logic [15:0] a, input logic [15:0] d, input logic exp_cmd);
    @(posedge core_clk);
    array_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    array_req <= '0;
    #1;
    chk_bit(cmd_seq_start, exp_cmd, "command sequence start");
  endtask

  task automatic arr_rd(input logic exp);
    @(posedge core_clk);
    array_req <= '{wr: 1'b0, rd: 1'b1, addr: 16'h9000, wdata: 16'h0000};
    #1;
    chk_bit(array_read_invalid, exp, "array read invalid");
    @(posedge core_clk);
    array_req <= '0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic do_reset(input logic [7:0] sec);
    int n;
    sec_byte = sec;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk_bit(nv_rd && nv_addr == NV_KEY_BASE, 1'b1, "first load request");
    // An early divider write must be dropped while the loads run
    reg_wr(OFF_CLKDIV, 8'h05);
    n = 0;
    while (load_done !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_bit(load_done, 1'b1, "loads finished");
    rd_chk(OFF_CLKDIV, 8'h00, "divider written during load");
  endtask

  task automatic lock_codes(input logic [1:0] c);
    do_reset({c, 4'b0110, c});
    rd_chk(OFF_SEC, {c, 4'b0110, c}, "security byte");
    chk_bit(backdoor_enabled, c == KEY_ENABLED, "backdoor enable");
    chk_bit(device_secured, c != LOCK_UNSECURED, "secured state");
    reg_wr(OFF_CFG, 8'h20);
    rd_chk(OFF_CFG, (c == KEY_ENABLED) ? 8'h20 : 8'h00, "key mode gate");
  endtask

  task automatic map_check();
    rd_chk(OFF_PROT, PROT_BYTE, "protection byte");
    chk_byte(flash_protection, PROT_BYTE, "protection port");
    for (int a = 2; a < 16; a++)
    begin
      if (a != 3)
      begin
        reg_wr(4'(a), 8'hff);
        rd_chk(4'(a), (a == 4) ? PROT_BYTE : 8'h00, "read-only offset");
      end
    end
    reg_wr(OFF_SEC, 8'h00);
    rd_chk(OFF_SEC, 8'ha9, "security write ignored");
  endtask

  task automatic divider_check(input logic [7:0] d, input int per);
    int n;
    reg_wr(OFF_CLKDIV, d);
    rd_chk(OFF_CLKDIV, {1'b1, d[6:0]}, "divider first write");
    reg_wr(OFF_CLKDIV, ~d);
    rd_chk(OFF_CLKDIV, {1'b1, d[6:0]}, "divider second write");
    n = 0;
    while (flash_clk_tick !== 1'b1 && n < 1100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (flash_clk_tick !== 1'b1 && n < 1100);
    chk_bit(n == per, 1'b1, "flash tick period");
  endtask

  task automatic cfg_irq_check();
    reg_wr(OFF_CFG, 8'hff);
    rd_chk(OFF_CFG, 8'he0, "configuration all ones");
    reg_wr(OFF_CFG, 8'h80);
    rd_chk(OFF_CFG, 8'h80, "configuration buffer enable only");
    @(posedge core_clk);
    buffer_empty_flag <= 1'b1;
    command_done_flag <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk_bit(irq_buffer_empty_req, 1'b1, "buffer empty request");
    chk_bit(irq_command_done_req, 1'b0, "command done masked");
    reg_wr(OFF_CFG, 8'h40);
    repeat (2) @(posedge core_clk);
    #1;
    chk_bit(irq_buffer_empty_req, 1'b0, "buffer empty masked");
    chk_bit(irq_command_done_req, 1'b1, "command done request");
    @(posedge core_clk);
    command_done_flag <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk_bit(irq_command_done_req, 1'b0, "command done flag low");
  endtask

  task automatic send_key(input logic [15:0] flip);
    logic [15:0] a;
    for (int i = 0; i < KEY_WORDS; i++)
    begin
      a = NV_KEY_BASE + 16'(2 * i);
      arr_wr(a, {nv_byte(a), nv_byte(a + 16'h0001)} ^ ((i == 1) ? flip : 16'h0000), 1'b0);
    end
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic key_check();
    arr_wr(16'h8000, 16'h1234, 1'b1);
    arr_rd(1'b0);
    reg_wr(OFF_CFG, 8'h20);
    arr_rd(1'b1);
    send_key(16'h0100);
    chk_bit(device_secured, 1'b1, "wrong key keeps lock");
    send_key(16'h0000);
    chk_bit(device_secured, 1'b0, "good key unlocks");
    rd_chk(OFF_SEC, 8'haa, "lock field forced");
  endtask

  initial
  begin
    for (int i = 0; i < 4; i++)
      lock_codes(2'(i));
    do_reset(8'ha9);
    map_check();
    divider_check(8'h03, 4);
    cfg_irq_check();
    key_check();
    do_reset(8'ha9);
    // Largest setting: prescale on, ratio field all ones, flash clock inside its band
    divider_check(8'h7f, 512);
    give_verdict();
  end
endmodule
